// ===== bfg_consts.svh
`ifndef BFG_CONSTS_SVH
`define BFG_CONSTS_SVH

// Flash page address width and fixed stall-region start page.
`define BFG_PAGE_W 9
`define BFG_STALL_START 9'h1E0

// Boot-loader region start page for each boot size selection.
// Every start lies at or above the stall-region start.
`define BFG_BOOT_START_0 9'h1E0
`define BFG_BOOT_START_1 9'h1F0
`define BFG_BOOT_START_2 9'h1F8
`define BFG_BOOT_START_3 9'h1FC

// Duration of one page erase or page write.
`define BFG_PROG_NS 4000
`define BFG_CLK_NS 10
`define BFG_PROG_CYC ((`BFG_PROG_NS + `BFG_CLK_NS - 1) / `BFG_CLK_NS)
`define BFG_CNT_W 16

// Register byte offsets.
`define BFG_OFS_CTRL 4'h0
`define BFG_OFS_LOCK 4'h4
`define BFG_OFS_FUSE 4'h8

// Control and status field positions.
`define BFG_CTRL_ACTIVE 0
`define BFG_CTRL_REEN 4
`define BFG_CTRL_BUSY 6

// Lock field positions and unprogrammed value.
`define BFG_LOCK_LDR_LO 0
`define BFG_LOCK_LDR_UP 1
`define BFG_LOCK_APP_LO 2
`define BFG_LOCK_APP_UP 3
`define BFG_LOCK_UNPROG 4'hF

`endif

// ===== bfg_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfg_core_model (
  // Clock
  input wire logic core_clk,
  // Guard side
  input wire bfg_pkg::bfg_core_rsp_t core_rsp,
  output var bfg_pkg::bfg_core_req_t core_req
);
  initial core_req = '0;
  // One request per call. The bench also reads the busy region while the flag is still set.
  task automatic issue(input logic st, input bfg_pkg::bfg_op_t op, input logic [8:0] pg,
    input logic [8:0] pc, input logic ivl, output bfg_pkg::bfg_core_rsp_t r);
    @(posedge core_clk);
    core_req.spm_req <= st;
    core_req.lpm_req <= !st;
    core_req.spm_op <= op;
    core_req.spm_page <= pg;
    core_req.lpm_page <= pg;
    core_req.lock_data <= pg[3:0];
    core_req.pc_page <= pc;
    core_req.ivec_in_loader <= ivl;
    @(negedge core_clk);
    r = core_rsp;
    @(posedge core_clk);
    core_req.spm_req <= 1'b0;
    core_req.lpm_req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bfg_guard.sv
// Contract
// R1: Programming starts only when the store instruction runs from the boot-loader region.
// R2: Boot size fuses set the application / boot-loader boundary.
// R3: A fixed boundary splits flash into read-while-write and stall regions.
// R4: Programming a read-while-write page lets the core run from the stall region.
// R5: Programming a stall-region page halts the core for the whole operation.
// R6: Software avoids the busy read-while-write region and handles interrupts itself.
// R7: The boot-loader region always lies inside the stall region.
// R8: The busy flag reads one while the read-while-write region is blocked.
// R9: Software clears the busy flag before running read-while-write code.
// R10: Locks are programmed by software or programmer, restored only by chip erase.
// R11: The general write lock does not affect store-program flash writes.
// R12: The general read/write lock does not restrict table reads or stores.
// R13: Application locks both one: no restriction on the application region.
// R14: Application locks upper one, lower zero: stores to application blocked.
// R15: Application locks both zero: stores and boot-loader table reads blocked.
// R16: Application upper zero, lower one: boot-loader table reads blocked, stores allowed.
// R17: Application read lock with vectors in boot-loader: interrupts off in application.
// R18: Boot-loader locks both one: no restriction on the boot-loader region.
// R19: Boot-loader upper one, lower zero: stores to boot-loader blocked.
// R20: Boot-loader locks both zero: stores and application table reads blocked.
// R21: Boot-loader upper zero, lower one: application table reads of it blocked.
// R22: Boot-loader read lock with vectors in application: interrupts off in boot-loader.
// R23: Busy flag clears on read re-enable after completion or on page load.
// R24: Each access is classified by page against both boundaries before deciding.
`timescale 1ns/1ps
`default_nettype none
`include "bfg_consts.svh"

module bfg_guard (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Avalon-MM register slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Fuses and non-volatile lock image
  input wire logic [1:0] boot_size_select,
  input wire logic [3:0] nv_lock_init,
  // External programming port
  input wire logic ext_lock_wr,
  input wire logic [3:0] ext_lock_data,
  input wire logic chip_erase,
  // Processor core
  input wire bfg_pkg::bfg_core_req_t core_req,
  output bfg_pkg::bfg_core_rsp_t core_rsp
);

  bfg_pkg::bfg_st_t st_ff;
  bfg_pkg::bfg_st_t nxt_st;
  logic [`BFG_PAGE_W-1:0] boot_start;
  logic pc_in_loader;
  logic spm_in_loader;
  logic spm_in_stall;
  logic lpm_in_loader;
  logic lpm_in_stall;
  logic pc_in_stall;
  logic wr_blocked;
  logic lpm_lock_deny;
  logic spm_ok;
  logic spm_start;
  logic reg_access;
  logic reenable_wr;

  // Boot size selects where the boot-loader region starts. [R2] [R7]
  always_comb begin
    case (boot_size_select)
      2'h0: boot_start = `BFG_BOOT_START_0;
      2'h1: boot_start = `BFG_BOOT_START_1;
      2'h2: boot_start = `BFG_BOOT_START_2;
      default: boot_start = `BFG_BOOT_START_3;
    endcase
  end

  // Every page is classified against both boundaries first. [R24] [R3]
  assign pc_in_loader = core_req.pc_page >= boot_start;
  assign spm_in_loader = core_req.spm_page >= boot_start;
  assign lpm_in_loader = core_req.lpm_page >= boot_start;
  assign spm_in_stall = core_req.spm_page >= `BFG_STALL_START;
  assign lpm_in_stall = core_req.lpm_page >= `BFG_STALL_START;
  assign pc_in_stall = core_req.pc_page >= `BFG_STALL_START;

  // A lower lock bit at zero forbids stores into its region. [R13] [R14] [R15] [R16]
  // [R18] [R19] [R20]
  assign wr_blocked = spm_in_loader ? !st_ff.locks.loader_lower : !st_ff.locks.app_lower;

  // An upper lock bit at zero forbids table reads from the other region. [R15] [R16]
  // [R20] [R21]
  always_comb begin
    lpm_lock_deny = 1'b0;
    if (pc_in_loader && !lpm_in_loader) begin
      lpm_lock_deny = !st_ff.locks.app_upper;
    end else if (!pc_in_loader && lpm_in_loader) begin
      lpm_lock_deny = !st_ff.locks.loader_upper;
    end
  end

  // The general memory lock modes never enter this decision. [R11] [R12]
  // Stores run only from the boot-loader region while idle; erase or write also needs the target region's lower lock bit at one. [R1]
  always_comb begin
    spm_ok = pc_in_loader && (st_ff.state == bfg_pkg::BFG_IDLE);
    if ((core_req.spm_op == bfg_pkg::BFG_OP_ERASE) ||
        (core_req.spm_op == bfg_pkg::BFG_OP_WRITE)) begin
      spm_ok = spm_ok && !wr_blocked;
    end
  end
  assign spm_start = core_req.spm_req && spm_ok;

  assign reg_access = avs_read || avs_write;
  // A write lands only at the edge at which the master sees waitrequest low.
  assign reenable_wr = avs_write && st_ff.ack && (avs_address == `BFG_OFS_CTRL) &&
                       avs_writedata[`BFG_CTRL_REEN];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = reg_access && !st_ff.ack;
    nxt_st.rdata = 32'h0000_0000;
    if (avs_read && !st_ff.ack) begin
      case (avs_address)
        `BFG_OFS_CTRL: begin
          nxt_st.rdata[`BFG_CTRL_BUSY] = st_ff.region_busy_flag; // [R8]
          nxt_st.rdata[`BFG_CTRL_ACTIVE] = (st_ff.state == bfg_pkg::BFG_BUSY);
        end
        `BFG_OFS_LOCK: nxt_st.rdata[3:0] = st_ff.locks;
        `BFG_OFS_FUSE: nxt_st.rdata[1:0] = boot_size_select;
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // Locks only move from one to zero; chip erase alone restores them. [R10]
    if (avs_write && st_ff.ack && (avs_address == `BFG_OFS_LOCK)) begin
      nxt_st.locks = nxt_st.locks & avs_writedata[3:0];
    end
    if (ext_lock_wr) begin
      nxt_st.locks = nxt_st.locks & ext_lock_data;
    end
    // Re-enable is ignored while an erase or write is still running. [R23]
    if (reenable_wr && (st_ff.state == bfg_pkg::BFG_IDLE)) begin
      nxt_st.region_busy_flag = 1'b0;
    end
    case (st_ff.state)
      bfg_pkg::BFG_IDLE: begin
        if (spm_start) begin
          case (core_req.spm_op)
            bfg_pkg::BFG_OP_LOAD: nxt_st.region_busy_flag = 1'b0; // [R23]
            bfg_pkg::BFG_OP_LOCKSET: nxt_st.locks = nxt_st.locks & core_req.lock_data; // [R10]
            default: begin
              nxt_st.state = bfg_pkg::BFG_BUSY;
              nxt_st.cnt = `BFG_CNT_W'(`BFG_PROG_CYC - 1);
              // Stall-region target halts the core, otherwise the read-while-write region is blocked.
              nxt_st.halting = spm_in_stall; // [R4] [R5]
              if (!spm_in_stall) begin
                nxt_st.region_busy_flag = 1'b1; // [R8]
              end
            end
          endcase
        end
      end
      bfg_pkg::BFG_BUSY: begin
        if (st_ff.cnt == '0) begin
          nxt_st.state = bfg_pkg::BFG_IDLE;
          nxt_st.halting = 1'b0;
        end else begin
          nxt_st.cnt = st_ff.cnt - 1'b1;
        end
      end
      default: nxt_st.state = bfg_pkg::BFG_IDLE;
    endcase
    if (chip_erase) begin
      nxt_st.locks = `BFG_LOCK_UNPROG; // [R10]
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff.state <= bfg_pkg::BFG_IDLE;
      st_ff.cnt <= '0;
      st_ff.region_busy_flag <= 1'b0;
      st_ff.halting <= 1'b0;
      // Locks are non-volatile, so reset reloads their stored image.
      st_ff.locks <= nv_lock_init;
      st_ff.ack <= 1'b0;
      st_ff.rdata <= 32'h0000_0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign avs_waitrequest = reg_access && !st_ff.ack;
  assign avs_readdata = st_ff.rdata;

  always_comb begin
    core_rsp.spm_accept = spm_start;
    core_rsp.spm_refuse = core_req.spm_req && !spm_ok; // [R1]
    core_rsp.cpu_halt = st_ff.halting; // [R5]
    // The busy read-while-write region is off limits to table reads. [R4] [R6]
    core_rsp.lpm_deny = core_req.lpm_req &&
                        (lpm_lock_deny || (st_ff.region_busy_flag && !lpm_in_stall));
    // Flags a fetch the core should never make; software must avoid it. [R6] [R9]
    core_rsp.fetch_blocked = st_ff.region_busy_flag && !pc_in_stall;
    core_rsp.irq_disable =
      (!pc_in_loader && core_req.ivec_in_loader && !st_ff.locks.app_upper) || // [R17]
      (pc_in_loader && !core_req.ivec_in_loader && !st_ff.locks.loader_upper); // [R22]
    core_rsp.region_busy_flag = st_ff.region_busy_flag; // [R8]
  end

endmodule

`default_nettype wire

// ===== bfg_guard_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfg_consts.svh"
module bfg_guard_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Observed ports
  input wire logic avs_write,
  input wire logic [1:0] boot_size_select,
  input wire bfg_pkg::bfg_core_req_t core_req,
  input wire bfg_pkg::bfg_core_rsp_t core_rsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [8:0] bs;
  logic prog;
  assign bs = boot_size_select == 2'h0 ? `BFG_BOOT_START_0 : boot_size_select == 2'h1 ?
    `BFG_BOOT_START_1 : boot_size_select == 2'h2 ? `BFG_BOOT_START_2 : `BFG_BOOT_START_3;
  assign prog = core_rsp.spm_accept && (core_req.spm_op == bfg_pkg::BFG_OP_ERASE ||
    core_req.spm_op == bfg_pkg::BFG_OP_WRITE);
  logic [`BFG_CNT_W-1:0] halt_run;
  // Counting the halt lets its length be judged without a delay of hundreds of cycles.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      halt_run <= '0;
    end else if (core_rsp.cpu_halt) begin
      halt_run <= halt_run + 1'b1;
    end else begin
      halt_run <= '0;
    end
  end
  chk_run_loader: assert property (
    core_req.spm_req && core_req.pc_page < bs |-> core_rsp.spm_refuse && !core_rsp.spm_accept)
    else $error("store accepted outside loader");
  chk_stall_halt: assert property (
    prog && core_req.spm_page >= `BFG_STALL_START |=> core_rsp.cpu_halt [*8])
    else $error("halt missing");
  chk_halt_span: assert property (
    $fell(core_rsp.cpu_halt) |-> halt_run == `BFG_PROG_CYC)
    else $error("halt length wrong");
  chk_halt_bound: assert property (
    core_rsp.cpu_halt |-> halt_run < `BFG_PROG_CYC)
    else $error("halt too long");
  chk_loader_halt: assert property (
    prog && core_req.spm_page >= bs |=> core_rsp.cpu_halt) else $error("loader not stalled");
  chk_rww_run: assert property (
    prog && core_req.spm_page < `BFG_STALL_START |=> core_rsp.region_busy_flag &&
    !core_rsp.cpu_halt) else $error("busy flag or halt wrong");
  chk_busy_deny: assert property (
    core_rsp.region_busy_flag && core_req.lpm_req && core_req.lpm_page < `BFG_STALL_START
    |-> core_rsp.lpm_deny) else $error("busy region read allowed");
  chk_load_clear: assert property (
    core_rsp.spm_accept && core_req.spm_op == bfg_pkg::BFG_OP_LOAD |=>
    !core_rsp.region_busy_flag) else $error("load left flag set");
  chk_flag_hold: assert property (
    core_rsp.region_busy_flag && !avs_write && !core_req.spm_req |=> core_rsp.region_busy_flag)
    else $error("busy flag dropped");
endmodule
bind bfg_guard bfg_guard_sva bfg_guard_sva_i (.core_clk(core_clk), .rst(rst),
  .avs_write(avs_write), .boot_size_select(boot_size_select), .core_req(core_req),
  .core_rsp(core_rsp));
`default_nettype wire

// ===== bfg_pkg.sv
`include "bfg_consts.svh"
`default_nettype none

package bfg_pkg;

  typedef enum logic [1:0] {
    BFG_OP_LOAD,
    BFG_OP_ERASE,
    BFG_OP_WRITE,
    BFG_OP_LOCKSET
  } bfg_op_t;

  typedef enum logic {
    BFG_IDLE,
    BFG_BUSY
  } bfg_state_t;

  typedef struct packed {
    logic app_upper;
    logic app_lower;
    logic loader_upper;
    logic loader_lower;
  } bfg_lock_t;

  typedef struct packed {
    logic spm_req;
    bfg_op_t spm_op;
    logic [`BFG_PAGE_W-1:0] spm_page;
    logic [3:0] lock_data;
    logic lpm_req;
    logic [`BFG_PAGE_W-1:0] lpm_page;
    logic [`BFG_PAGE_W-1:0] pc_page;
    logic ivec_in_loader;
  } bfg_core_req_t;

  typedef struct packed {
    logic spm_accept;
    logic spm_refuse;
    logic lpm_deny;
    logic cpu_halt;
    logic irq_disable;
    logic fetch_blocked;
    logic region_busy_flag;
  } bfg_core_rsp_t;

  typedef struct packed {
    bfg_state_t state;
    logic [`BFG_CNT_W-1:0] cnt;
    logic region_busy_flag;
    logic halting;
    bfg_lock_t locks;
    logic ack;
    logic [31:0] rdata;
  } bfg_st_t;

endpackage

`default_nettype wire

// ===== test_bfg_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "bfg_consts.svh"
module test_bfg_guard;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, ext_lock_wr, chip_erase;
  logic [3:0] avs_address, nv_lock_init, ext_lock_data;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [1:0] boot_size_select;
  bfg_pkg::bfg_core_req_t core_req;
  bfg_pkg::bfg_core_rsp_t core_rsp, r;
  int err_total, cmp_count, n;
  bfg_guard bfg_guard_i (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .boot_size_select(boot_size_select), .nv_lock_init(nv_lock_init),
    .ext_lock_wr(ext_lock_wr), .ext_lock_data(ext_lock_data), .chip_erase(chip_erase),
    .core_req(core_req), .core_rsp(core_rsp));
  bfg_core_model bfg_core_model_i (.core_clk(core_clk), .core_rsp(core_rsp),
    .core_req(core_req));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) begin
      err_total++;
      conclude();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic t_refuse;
    boot_size_select <= 2'h3;
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h010, 9'h1F8, 0, r);
    chk("refuse small boot", r.spm_refuse, 1);
    bus(0, 4'h8, 0);
    chk("fuse view", rd, 32'h3);
    boot_size_select <= 2'h0;
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h010, 9'h000, 0, r);
    chk("refuse app pc", r.spm_refuse, 1);
  endtask
  task automatic t_rww;
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h010, 9'h1F0, 0, r);
    chk("accept", r.spm_accept, 1);
    bus(0, 4'h0, 0);
    chk("ctrl busy", rd, 32'h41);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h1E8, 9'h1F0, 0, r);
    chk("stall read", {r.lpm_deny, r.cpu_halt}, 0);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h010, 9'h1F0, 0, r);
    chk("busy read", r.lpm_deny, 1);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h1E8, 9'h010, 0, r);
    chk("rww fetch", {r.fetch_blocked, r.lpm_deny}, 32'h2);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h1E8, 9'h1F0, 0, r);
    chk("busy refuse", r.spm_refuse, 1);
    repeat (400) @(posedge core_clk);
    bus(1, 4'h0, 32'h10);
    bus(0, 4'h0, 0);
    chk("ctrl clear", rd, 0);
    bus(0, 4'hC, 0);
    chk("unmapped", rd, 0);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h020, 9'h1F0, 0, r);
    chk("accept again", r.spm_accept, 1);
    repeat (400) @(posedge core_clk);
    bus(0, 4'h0, 0);
    chk("flag stands", rd, 32'h40);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_LOAD, 9'h020, 9'h1F0, 0, r);
    chk("load accept", r.spm_accept, 1);
    bus(0, 4'h0, 0);
    chk("load clear", rd, 0);
  endtask
  task automatic t_stall;
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_WRITE, 9'h1E4, 9'h1F0, 0, r);
    chk("loader store", r.spm_accept, 1);
    n = 0;
    @(negedge core_clk);
    while (core_rsp.cpu_halt === 1'b1 && n < 600) begin
      n++;
      @(negedge core_clk);
    end
    chk("halt cycles", n, `BFG_PROG_CYC);
  endtask
  task automatic t_locks;
    bus(1, 4'h4, 32'hB);
    bus(0, 4'h4, 0);
    chk("lock write", rd, 32'hB);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h010, 9'h1F0, 0, r);
    chk("app store lock", r.spm_refuse, 1);
    @(posedge core_clk);
    ext_lock_wr <= 1'b1;
    ext_lock_data <= 4'hA;
    @(posedge core_clk);
    ext_lock_wr <= 1'b0;
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h1F4, 9'h1F0, 0, r);
    chk("loader store lock", r.spm_refuse, 1);
    chip_erase <= 1'b1;
    @(posedge core_clk);
    chip_erase <= 1'b0;
    bus(0, 4'h4, 0);
    chk("chip erase", rd, 32'hF);
    bus(1, 4'h4, 32'h7);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h010, 9'h1F0, 0, r);
    chk("app read lock", r.lpm_deny, 1);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h1F0, 9'h010, 1, r);
    chk("app irq off", r.irq_disable, 1);
    bus(1, 4'h4, 32'hD);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h1F0, 9'h010, 0, r);
    chk("loader read lock", r.lpm_deny, 1);
    bfg_core_model_i.issue(0, bfg_pkg::BFG_OP_LOAD, 9'h010, 9'h1F0, 0, r);
    chk("loader irq off", r.irq_disable, 1);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_LOCKSET, 9'h008, 9'h1F0, 0, r);
    bus(0, 4'h4, 0);
    chk("lock set", rd, 0);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h010, 9'h1F0, 0, r);
    chk("app full lock", r.spm_refuse, 1);
    bfg_core_model_i.issue(1, bfg_pkg::BFG_OP_ERASE, 9'h1F4, 9'h1F0, 0, r);
    chk("loader full lock", r.spm_refuse, 1);
  endtask
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    {avs_read, avs_write, ext_lock_wr, chip_erase} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    ext_lock_data = 4'hF;
    nv_lock_init = 4'hF;
    boot_size_select = 2'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    t_refuse();
    t_rww();
    t_stall();
    t_locks();
    conclude();
  end
endmodule
`default_nettype wire
